// File: pkg/irupc_pkg.sv
/*
 * irupc_pkg: constants shared by the infrared pulse codec.
 * Assumes one system clock; the bit-rate tick comes from the 16x bit clock pin, sampled on it.
 */
package irupc_pkg;
	// system clock and bit timing
	localparam int unsigned SYS_CLK_HZ = 50000000;
	localparam int unsigned MAX_BAUD = 115200;
	localparam int unsigned TICKS_PER_BIT = 16;
	localparam logic [3:0] TICK_LAST = 4'hF;
	// encoder pulse placement, in ticks from the start of a low bit
	localparam logic [3:0] ENC_PULSE_START = 4'h7;
	localparam logic [3:0] ENC_PULSE_END = 4'hA;
	// decoder: one more than the ticks from the pulse edge to the host output change
	localparam logic [3:0] DEC_DELAY = 4'h4;
	// reset filter length in system clocks
	localparam logic [3:0] RST_FILT_LEN = 4'h8;
	// output levels during reset
	localparam logic HOST_IDLE = 1'b1;
	localparam logic PULSE_OFF = 1'b0;
	// shared bit-period state encoding
	typedef enum logic [0:0] {
		IRUPC_IDLE = 1'b0,
		IRUPC_BIT = 1'b1
	} irupc_state_t;
endpackage

// File: rtl/irupc_sync.sv
/*
 * irupc_sync: two flip-flop synchroniser for asynchronous pins.
 * Assumes the input may change at any time relative to sys_clk_i.
 */
`timescale 1ns/1ps
module irupc_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// asynchronous level in, synchronised level out
	input wire logic async_i,
	output logic sync_o
);
	logic meta;
	logic next_meta;
	logic next_sync;

	// first stage feeds only the second
	always_comb begin
		next_meta = async_i;
		next_sync = meta;
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta <= RESET_VAL;
			sync_o <= RESET_VAL;
		end else begin
			meta <= next_meta;
			sync_o <= next_sync;
		end
	end
endmodule

// File: rtl/irupc_codec.sv
/*
 * irupc_codec: infrared pulse encoder/decoder between a host UART and an optical transceiver.
 * Assumes bit_clock_x16_input is a pin toggling at 16x the baud rate, slower than sys_clk_i / 4.
 */
`timescale 1ns/1ps
module irupc_codec (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// pins: active-low reset and the 16x bit clock
	input wire logic reset_pin_n_i,
	input wire logic bit_clock_x16_input_i,
	// host uart side
	input wire logic host_serial_i,
	output logic host_serial_o,
	// optical transceiver side
	input wire logic optical_pulse_in_i,
	output logic optical_pulse_out_o
);
	import irupc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic rst_pin_n_s;
	logic bclk_s;
	logic host_in_s;
	logic pulse_in_s;

	irupc_sync #(.RESET_VAL(1'b0)) u_sync_rst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.async_i(reset_pin_n_i), .sync_o(rst_pin_n_s));
	irupc_sync #(.RESET_VAL(1'b0)) u_sync_bclk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.async_i(bit_clock_x16_input_i), .sync_o(bclk_s));
	irupc_sync #(.RESET_VAL(1'b1)) u_sync_host (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.async_i(host_serial_i), .sync_o(host_in_s));
	irupc_sync #(.RESET_VAL(1'b1)) u_sync_pulse (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.async_i(optical_pulse_in_i), .sync_o(pulse_in_s));

	////////////////////////////////////////////////////////////////////////
	// reset glitch filter: the pin must hold a new level for a full count
	logic run;
	logic [3:0] filt_cnt;
	logic next_run;
	logic [3:0] next_filt_cnt;

	// a shorter pulse restarts the count, so it never reaches the logic
	always_comb begin
		next_run = run;
		next_filt_cnt = 4'h0;
		if (rst_pin_n_s != run) begin
			next_filt_cnt = filt_cnt + 4'h1;
			if (filt_cnt == RST_FILT_LEN - 4'h1) begin
				next_run = rst_pin_n_s;
				next_filt_cnt = 4'h0;
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			run <= 1'b0;
			filt_cnt <= 4'h0;
		end else begin
			run <= next_run;
			filt_cnt <= next_filt_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bit clock edge detect gives a one-cycle tick enable
	logic bclk_d;
	logic tick;
	logic next_bclk_d;

	always_comb begin
		next_bclk_d = bclk_s;
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bclk_d <= 1'b0;
		end else begin
			bclk_d <= next_bclk_d;
		end
	end

	assign tick = bclk_s & ~bclk_d;

	////////////////////////////////////////////////////////////////////////
	// encoder: host low bit becomes a three-tick pulse after seven low ticks
	irupc_state_t enc_state;
	irupc_state_t next_enc_state;
	logic [3:0] enc_cnt;
	logic [3:0] next_enc_cnt;
	logic next_pulse_out;

	// each low bit restarts alignment at its own start, so baud drift does not accumulate
	always_comb begin
		next_enc_state = enc_state;
		next_enc_cnt = enc_cnt;
		next_pulse_out = PULSE_OFF;
		if (run && tick) begin
			case (enc_state)
				IRUPC_IDLE: begin
					if (!host_in_s) begin
						next_enc_state = IRUPC_BIT;
						next_enc_cnt = 4'h1;
					end
				end
				IRUPC_BIT: begin
					next_enc_cnt = enc_cnt + 4'h1;
					if (enc_cnt == TICK_LAST) begin
						// deciding here would still see the old bit; the next one is sampled at its first tick
						next_enc_cnt = 4'h0;
						next_enc_state = IRUPC_IDLE;
					end
				end
				default: begin
					next_enc_state = IRUPC_IDLE;
				end
			endcase
		end
		if (run && enc_state == IRUPC_BIT && enc_cnt >= ENC_PULSE_START && enc_cnt < ENC_PULSE_END) begin
			next_pulse_out = ~PULSE_OFF;
		end
		if (run && enc_state == IRUPC_BIT && !tick) begin
			next_pulse_out = optical_pulse_out_o;
		end
		if (!run) begin
			next_enc_state = IRUPC_IDLE;
			next_enc_cnt = 4'h0;
			next_pulse_out = PULSE_OFF;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			enc_state <= IRUPC_IDLE;
			enc_cnt <= 4'h0;
			optical_pulse_out_o <= PULSE_OFF;
		end else begin
			enc_state <= next_enc_state;
			enc_cnt <= next_enc_cnt;
			optical_pulse_out_o <= next_pulse_out;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// decoder: a low pulse starts a sixteen-tick low bit on the host line
	irupc_state_t dec_state;
	irupc_state_t next_dec_state;
	logic [3:0] dec_cnt;
	logic [3:0] next_dec_cnt;
	logic next_host_out;
	logic pulse_seen;
	logic next_pulse_seen;

	// a pulse arriving during a bit is latched and extends the low run by another period
	always_comb begin
		next_dec_state = dec_state;
		next_dec_cnt = dec_cnt;
		next_host_out = host_serial_o;
		next_pulse_seen = pulse_seen | (dec_state == IRUPC_BIT && !pulse_in_s);
		if (run && tick) begin
			case (dec_state)
				IRUPC_IDLE: begin
					next_pulse_seen = 1'b0;
					if (!pulse_in_s) begin
						next_dec_state = IRUPC_BIT;
						next_dec_cnt = 4'h1;
					end
				end
				IRUPC_BIT: begin
					// the counter wraps every sixteen ticks; the host level tells first pass from bit end
					next_dec_cnt = dec_cnt + 4'h1;
					if (dec_cnt == DEC_DELAY - 4'h1) begin
						next_pulse_seen = 1'b0;
						if (host_serial_o) begin
							next_host_out = 1'b0;
						end else if (pulse_seen || !pulse_in_s) begin
							next_host_out = 1'b0;
						end else begin
							next_host_out = HOST_IDLE;
							next_dec_state = IRUPC_IDLE;
						end
					end
				end
				default: begin
					next_dec_state = IRUPC_IDLE;
				end
			endcase
		end
		if (!run) begin
			next_dec_state = IRUPC_IDLE;
			next_dec_cnt = 4'h0;
			next_host_out = HOST_IDLE;
			next_pulse_seen = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dec_state <= IRUPC_IDLE;
			dec_cnt <= 4'h0;
			host_serial_o <= HOST_IDLE;
			pulse_seen <= 1'b0;
		end else begin
			dec_state <= next_dec_state;
			dec_cnt <= next_dec_cnt;
			host_serial_o <= next_host_out;
			pulse_seen <= next_pulse_seen;
		end
	end
endmodule

// File: bench/irupc_props.sv
/* irupc_props: port checker for irupc_codec.
   Assumes the bit clock is far slower than sys_clk_i. */
`timescale 1ns/1ps
module irupc_props (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// pins
	input wire logic reset_pin_n_i,
	input wire logic bit_clock_x16_input_i,
	input wire logic host_serial_i,
	input wire logic host_serial_o,
	input wire logic optical_pulse_in_i,
	input wire logic optical_pulse_out_o
);
	logic bq;
	logic [7:0] lo_n;
	logic [4:0] hi_n, h_age, o_age, pin_n;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////
	// widths and line ages in ticks, reset pin age in clocks; ages saturate so long idle cannot wrap
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bq <= 1'b0;
			lo_n <= 8'h00;
			hi_n <= 5'h00;
			h_age <= 5'h1F;
			o_age <= 5'h1F;
			pin_n <= 5'h00;
		end else begin
			bq <= bit_clock_x16_input_i;
			lo_n <= host_serial_o ? 8'h00 : lo_n + {7'h0, bit_clock_x16_input_i & ~bq};
			hi_n <= !optical_pulse_out_o ? 5'h00 : hi_n + {4'h0, bit_clock_x16_input_i & ~bq};
			h_age <= !host_serial_i ? 5'h00 : h_age + {4'h0, bit_clock_x16_input_i & ~bq & (h_age != 5'h1F)};
			o_age <= !optical_pulse_in_i ? 5'h00 : o_age + {4'h0, bit_clock_x16_input_i & ~bq & (o_age != 5'h1F)};
			pin_n <= reset_pin_n_i ? 5'h00 : pin_n + {4'h0, pin_n != 5'h1F};
		end
	end
	////////////////////////////////////////
	pulse_width_a: assert property ($fell(optical_pulse_out_o) |-> hi_n == 5'h03)
		else $error("emitter pulse not three ticks");
	pulse_cap_a: assert property (hi_n <= 5'h03) else $error("emitter pulse too long");
	host_hold_a: assert property ($rose(host_serial_o) |-> lo_n[3:0] == 4'h0 && lo_n != 8'h00)
		else $error("host low not whole bit periods");
	enc_cause_a: assert property ($rose(optical_pulse_out_o) |-> h_age == 5'h00)
		else $error("pulse without host low bit");
	enc_idle_a: assert property (h_age >= 5'h0C |-> !optical_pulse_out_o)
		else $error("pulse on a high bit");
	dec_cause_a: assert property ($fell(host_serial_o) |-> o_age <= 5'h06)
		else $error("host low without a pulse");
	dec_idle_a: assert property (o_age >= 5'h18 |-> host_serial_o)
		else $error("host low with no pulse");
	rst_idle_a: assert property (pin_n >= 5'h0E |-> host_serial_o && !optical_pulse_out_o)
		else $error("outputs not idle in reset");
	cover property ($rose(optical_pulse_out_o));
	cover property ($fell(host_serial_o));
	cover property (pin_n == 5'h14);
endmodule
bind irupc_codec irupc_props u_props (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reset_pin_n_i(reset_pin_n_i),
	.bit_clock_x16_input_i(bit_clock_x16_input_i), .host_serial_i(host_serial_i), .host_serial_o(host_serial_o),
	.optical_pulse_in_i(optical_pulse_in_i), .optical_pulse_out_o(optical_pulse_out_o));

// File: bench/irupc_xcvr_model.sv
/* irupc_xcvr_model: optical transceiver receive side.
   Assumes the bench owns the 16x bit clock. */
`timescale 1ns/1ps
module irupc_xcvr_model (
	// bit clock in, detect pulse out
	input wire logic bit_clock_x16_input_i,
	output logic optical_pulse_in_o
);
	// no light reads high
	initial optical_pulse_in_o = 1'b1;
	// 8N1 lsb first; a zero is a 3-tick low pulse, a one no pulse
	task automatic send(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			optical_pulse_in_o = f[i];
			repeat (3) @(posedge bit_clock_x16_input_i);
			optical_pulse_in_o = 1'b1;
			repeat (13) @(posedge bit_clock_x16_input_i);
		end
	endtask
endmodule

// File: bench/tb_top.sv
/* tb_top: bench for irupc_codec.
   Assumes the bench supplies clock, bit clock and host line. */
`timescale 1ns/1ps
module tb_top;
	logic clk = 0, rst = 1, pin_n = 0, bclk = 0, tx = 1, rx, ir_in, ir_out;
	int n_errors = 0, cmp_count = 0, cyc = 0, np = 0;
	logic [7:0] b, got;
	irupc_codec dut (.sys_clk_i(clk), .rst_i(rst), .reset_pin_n_i(pin_n), .bit_clock_x16_input_i(bclk),
		.host_serial_i(tx), .host_serial_o(rx), .optical_pulse_in_i(ir_in), .optical_pulse_out_o(ir_out));
	irupc_xcvr_model xcvr (.bit_clock_x16_input_i(bclk), .optical_pulse_in_o(ir_in));
	////////////////////////////////////////
	// 50 MHz clock; bit clock at sys/8 keeps well inside the sync limit
	initial forever #10 clk = ~clk;
	always begin repeat (4) @(posedge clk); #2 bclk = ~bclk; end
	always @(posedge ir_out) np++;
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			stop_test();
		end
	end
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("errors %0d checks %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// one pulse per zero bit, start bit included
	function automatic logic [7:0] nzero(input logic [7:0] d);
		nzero = 8'h01;
		for (int i = 0; i < 8; i++) nzero += {7'h0, ~d[i]};
	endfunction
	task automatic host_send(input logic [7:0] d);
		np = 0;
		for (int i = 0; i < 11; i++) begin
			@(posedge clk);
			#2 tx = (i == 0) ? 1'b0 : (i < 9) ? d[i-1] : 1'b1;
			repeat (16) @(posedge bclk);
		end
		chk("pulses", 8'(np), nzero(d));
	endtask
	task automatic ir_recv(input logic [7:0] d);
		fork xcvr.send(d); join_none
		// look after the edge so the registered output has settled
		for (int i = 0; i < 300 && rx; i++) begin
			@(posedge clk);
			#2;
		end
		repeat (8) @(posedge bclk);
		chk("start", {7'h0, rx}, 8'h00);
		for (int i = 0; i < 8; i++) begin
			repeat (16) @(posedge bclk);
			got[i] = rx;
		end
		chk("byte", got, d);
		repeat (32) @(posedge bclk);
		chk("idle", {7'h0, rx}, 8'h01);
	endtask
	////////////////////////////////////////
	initial begin
		void'($urandom(16));
		repeat (20) @(posedge clk);
		#2 rst = 0;
		// the reset pin is released only once the system is up, then the filter gets time to pass it
		repeat (4) @(posedge clk);
		#2 pin_n = 1;
		repeat (16) @(posedge clk);
		for (int k = 0; k < 7; k++) begin
			b = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
			// short low glitch mid-frame must not disturb encoding
			if (k == 0) begin
				fork begin
					repeat (300) @(posedge clk);
					#2 pin_n = 0;
					repeat (4) @(posedge clk);
					#2 pin_n = 1;
				end join_none
			end
			host_send(b);
			ir_recv(b);
		end
		// held reset pin with the host line low: outputs idle
		@(posedge clk);
		#2 pin_n = 0;
		tx = 0;
		np = 0;
		repeat (40) @(posedge clk);
		#2 chk("in reset", {np[5:0], ir_out, rx}, 8'h01);
		pin_n = 1;
		repeat (32) @(posedge bclk);
		@(posedge clk);
		#2 tx = 1;
		repeat (16) @(posedge bclk);
		chk("after release", 8'(np), 8'h02);
		stop_test();
	end
endmodule
